//--- shared/qdc_phase_if.sv
// qdc_phase_if: filtered encoder phases from filter to decoder.
// assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface qdc_phase_if;
  logic [1:0] filt;
  modport src (output filt);
  modport dst (input filt);
endinterface : qdc_phase_if

//--- shared/qdc_pkg.sv
// qdc_pkg: shared widths, reset values and state codes of the
// quadrature decoder/counter.
// assumes a single 10 MHz system clock.
package qdc_pkg;

  localparam int CLK_PERIOD_NS = 100;
  localparam int HIST_W = 4;
  localparam int QUAL_EDGES = 3;
  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;
  localparam int PHASES = 2;

  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [HIST_W-1:0] HIST_RST = 4'h0;
  localparam logic [PHASES-1:0] PHASE_RST = 2'h0;

  // gray-coded read-hold states along the two-byte read
  typedef enum logic [1:0] {
    QDC_LOADING = 2'b00,
    QDC_HELD = 2'b01,
    QDC_RELEASING = 2'b11
  } qdc_hold_type;

endpackage : qdc_pkg

//--- test/qdc_checker.sv
// qdc_checker: port assertions for qdc_top.
// assumes CE_I high and phase states four clocks apart.
`timescale 1ns/1ps
module qdc_checker
  import qdc_pkg::*;
(
  // watched ports
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic RESET_LOW_N_I,
  input wire logic ENCODER_PHASE_A_I,
  input wire logic ENCODER_PHASE_B_I,
  input wire logic OUTPUT_ENABLE_N_I,
  input wire logic BYTE_SEL_I,
  input wire logic [BYTE_W-1:0] READ_BUS_O,
  input wire logic READ_BUS_OE_O,
  input wire logic DECODER_COUNT_PULSE_O,
  input wire logic OVERFLOW_CARRY_PULSE_O,
  input wire logic COUNT_UP_O
);
  // pulses live between a rising and a falling edge
  default clocking @(negedge CLK_I); endclocking
  default disable iff (SRST_I || !RESET_LOW_N_I);
  bus_enable_a: assert property (
    READ_BUS_OE_O == !OUTPUT_ENABLE_N_I) else $error("bus enable");
  pulse_half_a: assert property (@(posedge CLK_I)
    !DECODER_COUNT_PULSE_O && !OVERFLOW_CARRY_PULSE_O) else $error("long");
  carry_count_a: assert property (
    OVERFLOW_CARRY_PULSE_O |-> DECODER_COUNT_PULSE_O) else $error("carry");
  dir_lead_a: assert property (
    DECODER_COUNT_PULSE_O |-> $stable(COUNT_UP_O)) else $error("dir lead");
  dir_hold_a: assert property (
    DECODER_COUNT_PULSE_O |=> $stable(COUNT_UP_O)) else $error("dir hold");
  filter_delay_a: assert property (DECODER_COUNT_PULSE_O |->
    $past(ENCODER_PHASE_A_I, 7) != $past(ENCODER_PHASE_A_I, 8) ||
    $past(ENCODER_PHASE_B_I, 7) != $past(ENCODER_PHASE_B_I, 8))
    else $error("count delay");
  dir_value_a: assert property (DECODER_COUNT_PULSE_O |->
    COUNT_UP_O == ($past(ENCODER_PHASE_A_I, 8) ==
    $past(ENCODER_PHASE_B_I, 7))) else $error("direction");
  hold_stable_a: assert property (
    !OUTPUT_ENABLE_N_I && !BYTE_SEL_I ##1 !BYTE_SEL_I |->
    $stable(READ_BUS_O)) else $error("held byte moved");
  reset_clear_a: assert property (
    @(posedge CLK_I) disable iff (SRST_I)
    !RESET_LOW_N_I |-> READ_BUS_O == 8'h00 && !COUNT_UP_O)
    else $error("reset");
endmodule : qdc_checker

bind qdc_top qdc_checker chk_i (.CLK_I, .SRST_I, .RESET_LOW_N_I,
  .ENCODER_PHASE_A_I, .ENCODER_PHASE_B_I, .OUTPUT_ENABLE_N_I, .BYTE_SEL_I,
  .READ_BUS_O, .READ_BUS_OE_O, .DECODER_COUNT_PULSE_O,
  .OVERFLOW_CARRY_PULSE_O, .COUNT_UP_O);

//--- test/qdc_host.sv
// qdc_host: host reader of the byte bus.
// assumes tasks are called from the bench on the block's clock.
`timescale 1ns/1ps
module qdc_host
  import qdc_pkg::*;
(
  // clock
  input wire logic clk_i,
  // bus
  output logic oe_n_o,
  output logic sel_o,
  input wire logic [BYTE_W-1:0] bus_i,
  input wire logic bus_oe_i
);
  wire [BYTE_W-1:0] line = bus_oe_i ? bus_i : 8'hzz;
  initial begin
    oe_n_o = 1'b1;
    sel_o = 1'b0;
  end
  // high byte kept two edges so the hold is engaged first
  task automatic read16(output logic [CNT_W-1:0] v);
    @(posedge clk_i);
    oe_n_o <= 1'b0;
    sel_o <= 1'b0;
    repeat (2) @(posedge clk_i);
    v[15:8] = line;
    sel_o <= 1'b1;
    @(posedge clk_i);
    v[7:0] = line;
    oe_n_o <= 1'b1;
    sel_o <= 1'b0;
    @(posedge clk_i);
  endtask : read16
  task automatic read8(output logic [BYTE_W-1:0] v);
    @(posedge clk_i);
    oe_n_o <= 1'b0;
    sel_o <= 1'b1;
    repeat (10) @(posedge clk_i);
    v = line;
    oe_n_o <= 1'b1;
    sel_o <= 1'b0;
    @(posedge clk_i);
  endtask : read8
endmodule : qdc_host

//--- test/test_qdc_top.sv
// test_qdc_top: self-checking bench for qdc_top.
// assumes qdc_checker is bound in; CE_I stays high.
`timescale 1ns/1ps
module test_qdc_top
  import qdc_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic rst_n = 1'b1;
  logic [1:0] ph = 2'b00;
  logic oe_n, sel, bus_oe, pulse, carry, up;
  logic [BYTE_W-1:0] bus, b8;
  logic [CNT_W-1:0] exp_cnt = 16'h0000, v, old;
  int failures = 0, n_compared = 0, n_pulse = 0, n_carry = 0;
  int exp_pulse = 0, exp_carry = 0;
  qdc_top dut (.CLK_I(clk), .SRST_I(srst), .CE_I(1'b1),
    .RESET_LOW_N_I(rst_n), .ENCODER_PHASE_A_I(ph[0]),
    .ENCODER_PHASE_B_I(ph[1]), .OUTPUT_ENABLE_N_I(oe_n), .BYTE_SEL_I(sel),
    .READ_BUS_O(bus), .READ_BUS_OE_O(bus_oe),
    .DECODER_COUNT_PULSE_O(pulse), .OVERFLOW_CARRY_PULSE_O(carry),
    .COUNT_UP_O(up));
  qdc_host host (.clk_i(clk), .oe_n_o(oe_n), .sel_o(sel), .bus_i(bus),
    .bus_oe_i(bus_oe));
  initial forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  always @(negedge clk) begin
    if (pulse === 1'b1) n_pulse++;
    if (carry === 1'b1) n_carry++;
  end
  task automatic chk(logic [CNT_W-1:0] seen, exp, string m);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask : chk
  function automatic logic [1:0] nxt(logic [1:0] s, logic u);
    return u ? {s[0], ~s[1]} : {~s[0], s[1]};
  endfunction : nxt
  // four clocks a state keeps each level over three clocks
  task automatic step(logic u);
    @(posedge clk);
    ph <= nxt(ph, u);
    if (u && exp_cnt == CNT_MAX || !u && exp_cnt == CNT_RST) exp_carry++;
    exp_cnt = u ? exp_cnt + 1'b1 : exp_cnt - 1'b1;
    exp_pulse++;
    repeat (3) @(posedge clk);
  endtask : step
  task automatic rd(logic [CNT_W-1:0] e, string m);
    repeat (8) @(posedge clk);
    host.read16(v);
    chk(v, e, m);
  endtask : rd
  task automatic wrap_up;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    #(CLK_PERIOD_NS * 5000);
    failures++;
    wrap_up;
  end
  initial begin
    void'($urandom(13586));
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    step(1'b0);
    rd(16'hFFFF, "underflow");
    step(1'b1);
    rd(exp_cnt, "overflow");
    repeat (4) step(1'b1);
    rd(exp_cnt, "four counts a cycle");
    @(posedge clk) rst_n <= 1'b0;
    @(posedge clk) rst_n <= 1'b1;
    exp_cnt = 16'h0000;
    rd(exp_cnt, "reset");
    old = exp_cnt;
    fork
      step(1'b1);
      begin
        // hold engages half a clock before the count lands
        repeat (6) @(posedge clk);
        host.read16(v);
      end
    join
    chk(v, old, "held during read");
    rd(exp_cnt, "resumed");
    fork
      step(1'b0);
      host.read8(b8);
    join
    chk({8'h00, b8}, {8'h00, exp_cnt[7:0]}, "byte mode");
    @(posedge clk) ph <= ~ph;
    rd(exp_cnt, "both phases moved");
    repeat (4) begin
      repeat (10) step(1'($urandom_range(1)));
      rd(exp_cnt, "random walk");
    end
    chk(16'(n_pulse), 16'(exp_pulse), "pulse count");
    chk(16'(n_carry), 16'(exp_carry), "carry count");
    wrap_up;
  end
endmodule : test_qdc_top

//--- verilog/qdc_filter.sv
// qdc_filter: four-bit history and three-edge qualifier per phase.
// assumes raw phases are sampled only on rising clock edges.
`timescale 1ns/1ps
module qdc_filter
  import qdc_pkg::*;
(
  // clock and control
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic rst_low_n_i,
  // raw phases, bit 0 is phase a
  input wire logic [PHASES-1:0] raw_i,
  // filtered phases
  qdc_phase_if.src phase
);

  genvar g;
  generate
    for (g = 0; g < PHASES; g++) begin : g_ch
      logic [HIST_W-1:0] hist_q;
      logic [HIST_W-1:0] hist_d;
      logic filt_q;
      logic filt_d;

      // bit 0 is the sampling stage, bits 3..1 the qualifying edges
      always_comb begin
        hist_d = hist_q;
        filt_d = filt_q;
        if (srst_i) begin
          hist_d = HIST_RST;
          filt_d = 1'b0;
        end else if (ce_i) begin
          hist_d = {hist_q[HIST_W-2:0], raw_i[g]};
          if (&hist_q[HIST_W-1:1]) begin
            filt_d = 1'b1;
          end else if (~|hist_q[HIST_W-1:1]) begin
            filt_d = 1'b0;
          end
        end
      end

      always_ff @(posedge clk_i or negedge rst_low_n_i) begin
        if (!rst_low_n_i) begin
          hist_q <= HIST_RST;
          filt_q <= 1'b0;
        end else begin
          hist_q <= hist_d;
          filt_q <= filt_d;
        end
      end

      assign phase.filt[g] = filt_q;
    end
  endgenerate

endmodule : qdc_filter

//--- verilog/qdc_inhibit.sv
// qdc_inhibit: falling-edge read-hold logic for the position latch.
// assumes output enable and byte select are synchronous to the clock.
`timescale 1ns/1ps
module qdc_inhibit
  import qdc_pkg::*;
(
  // clock and control
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic rst_low_n_i,
  // bus controls
  input wire logic oe_n_i,
  input wire logic sel_i,
  // hold towards the latch
  output logic inhibit_o
);

  qdc_hold_type state_q;
  qdc_hold_type state_d;

  always_comb begin
    state_d = state_q;
    if (srst_i) begin
      state_d = QDC_LOADING;
    end else if (ce_i) begin
      unique case (state_q)
        QDC_LOADING: begin
          // select high alone never engages the hold
          if (!oe_n_i && !sel_i) begin
            state_d = QDC_HELD;
          end
        end
        QDC_HELD: begin
          if (!oe_n_i && sel_i) begin
            state_d = QDC_RELEASING;
          end
        end
        QDC_RELEASING: begin
          if (oe_n_i) begin
            state_d = QDC_LOADING;
          end else if (!sel_i) begin
            state_d = QDC_HELD;
          end
        end
        default: state_d = QDC_LOADING;
      endcase
    end
  end

  always_ff @(negedge clk_i or negedge rst_low_n_i) begin
    if (!rst_low_n_i) begin
      state_q <= QDC_LOADING;
    end else begin
      state_q <= state_d;
    end
  end

  assign inhibit_o = (state_q != QDC_LOADING);

endmodule : qdc_inhibit

//--- verilog/qdc_top.sv
// qdc_top: quadrature decoder, 16-bit counter, position latch and
// two-byte read bus with count, direction and cascade outputs.
// assumes a free-running clock; the host drives the bus controls
// synchronously to it and joins the read bus from the enable.
//
// How it works
// - each phase sampled into four-bit history
// - filtered level needs three equal samples
// - accepted change reaches counter within seven clocks
// - one count per valid state transition
// - a leading b counts up, else down
// - double-phase changes need no error flag
// - sixteen-bit up/down counter on rising edges
// - counter wraps freely, no saturation
// - low reset input clears the counter
// - latch loads counter unless inhibited
// - low reset clears latch asynchronously
// - latch resumes loading after two-byte read
// - controls sampled on falling clock edge
// - low reset clears the inhibit state
// - selected latch byte driven while enabled
// - half-clock count pulse on each count
// - direction valid one clock around pulse edge
// - pulses and direction ignore inhibit
// - select low high byte, high low byte
// - half-clock cascade pulse on wrap
// - inhibit set and two-step clear sequence
`timescale 1ns/1ps
module qdc_top
  import qdc_pkg::*;
(
  // clock and resets
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic CE_I,
  input wire logic RESET_LOW_N_I,
  // encoder phases
  input wire logic ENCODER_PHASE_A_I,
  input wire logic ENCODER_PHASE_B_I,
  // host read bus
  input wire logic OUTPUT_ENABLE_N_I,
  input wire logic BYTE_SEL_I,
  output logic [BYTE_W-1:0] READ_BUS_O,
  output logic READ_BUS_OE_O,
  // count and cascade outputs
  output logic DECODER_COUNT_PULSE_O,
  output logic OVERFLOW_CARRY_PULSE_O,
  output logic COUNT_UP_O
);

  // returns {count, up} for one step between two phase states
  function automatic logic [1:0] qdc_decode(input logic [1:0] prev,
                                            input logic [1:0] cur);
    logic [1:0] res;
    res = 2'b00;
    // state is {b, a}; a leading b walks 00 01 11 10
    unique case ({prev, cur})
      4'b0001, 4'b0111, 4'b1110, 4'b1000: res = 2'b11;
      4'b0100, 4'b1101, 4'b1011, 4'b0010: res = 2'b10;
      // no change, or both phases moved at once: dropped without any flag
      default: res = 2'b00;
    endcase
    return res;
  endfunction : qdc_decode

  qdc_phase_if phase ();

  logic inhibit;

  qdc_filter u_filter (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .ce_i(CE_I),
    .rst_low_n_i(RESET_LOW_N_I),
    .raw_i({ENCODER_PHASE_B_I, ENCODER_PHASE_A_I}),
    .phase(phase.src)
  );

  qdc_inhibit u_inhibit (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .ce_i(CE_I),
    .rst_low_n_i(RESET_LOW_N_I),
    .oe_n_i(OUTPUT_ENABLE_N_I),
    .sel_i(BYTE_SEL_I),
    .inhibit_o(inhibit)
  );

  // decoder stage: registered so direction leads the count by a clock
  logic [1:0] prev_q;
  logic [1:0] prev_d;
  logic evt_q;
  logic evt_d;
  logic up_q;
  logic up_d;
  logic [1:0] step;

  always_comb begin
    step = qdc_decode(prev_q, phase.filt);
    prev_d = prev_q;
    evt_d = evt_q;
    up_d = up_q;
    if (SRST_I) begin
      prev_d = PHASE_RST;
      evt_d = 1'b0;
      up_d = 1'b0;
    end else if (CE_I) begin
      prev_d = phase.filt;
      evt_d = step[1];
      // direction only moves with a count, so it holds around the pulse
      if (step[1]) begin
        up_d = step[0];
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_LOW_N_I) begin
    if (!RESET_LOW_N_I) begin
      prev_q <= PHASE_RST;
      evt_q <= 1'b0;
      up_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      evt_q <= evt_d;
      up_q <= up_d;
    end
  end

  // position counter, latch and pulse toggles
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] latch_q;
  logic [CNT_W-1:0] latch_d;
  logic dcd_tog_q;
  logic dcd_tog_d;
  logic cas_tog_q;
  logic cas_tog_d;
  logic wrap;

  always_comb begin
    cnt_d = cnt_q;
    latch_d = latch_q;
    dcd_tog_d = dcd_tog_q;
    cas_tog_d = cas_tog_q;
    wrap = up_q ? (cnt_q == CNT_MAX) : (cnt_q == CNT_RST);
    if (SRST_I) begin
      cnt_d = CNT_RST;
      latch_d = CNT_RST;
      dcd_tog_d = 1'b0;
      cas_tog_d = 1'b0;
    end else if (CE_I) begin
      if (evt_q) begin
        // plain modular add: wraps without saturating
        cnt_d = up_q ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
        dcd_tog_d = ~dcd_tog_q;
        if (wrap) begin
          cas_tog_d = ~cas_tog_q;
        end
      end
      // latch takes the value the counter held before this edge
      if (!inhibit) begin
        latch_d = cnt_q;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_LOW_N_I) begin
    if (!RESET_LOW_N_I) begin
      cnt_q <= CNT_RST;
      latch_q <= CNT_RST;
      dcd_tog_q <= 1'b0;
      cas_tog_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      latch_q <= latch_d;
      dcd_tog_q <= dcd_tog_d;
      cas_tog_q <= cas_tog_d;
    end
  end

  // falling-edge copies close each pulse after half a clock
  logic dcd_fall_q;
  logic dcd_fall_d;
  logic cas_fall_q;
  logic cas_fall_d;

  always_comb begin
    dcd_fall_d = dcd_fall_q;
    cas_fall_d = cas_fall_q;
    if (SRST_I) begin
      dcd_fall_d = 1'b0;
      cas_fall_d = 1'b0;
    end else if (CE_I) begin
      dcd_fall_d = dcd_tog_q;
      cas_fall_d = cas_tog_q;
    end
  end

  always_ff @(negedge CLK_I or negedge RESET_LOW_N_I) begin
    if (!RESET_LOW_N_I) begin
      dcd_fall_q <= 1'b0;
      cas_fall_q <= 1'b0;
    end else begin
      dcd_fall_q <= dcd_fall_d;
      cas_fall_q <= cas_fall_d;
    end
  end

  // xor of two flops: no gating on the clock itself
  assign DECODER_COUNT_PULSE_O = dcd_tog_q ^ dcd_fall_q;
  assign OVERFLOW_CARRY_PULSE_O = cas_tog_q ^ cas_fall_q;
  assign COUNT_UP_O = up_q;

  // byte mux straight from the latch flops
  assign READ_BUS_O = BYTE_SEL_I ? latch_q[BYTE_W-1:0]
                                 : latch_q[CNT_W-1:BYTE_W];
  assign READ_BUS_OE_O = ~OUTPUT_ENABLE_N_I;

endmodule : qdc_top
